// ### verilog/charge_ctrl.sv
// charge sequencing controller: state machine, host registers, setting ramps,
// isolation switch drive and switch detection
// assumes analog comparator flags already deglitched, arriving asynchronously
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module charge_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [charge_ctrl_pkg::ADDR_W-1:0] i_addr,
    input wire logic [charge_ctrl_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [charge_ctrl_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_vin_detect,
    input wire logic i_headroom_ok,
    input wire logic i_above_safe,
    input wire logic i_above_pre,
    input wire logic i_near_charge_voltage,
    input wire logic i_above_recharge,
    input wire logic i_below_end_current,
    input wire logic i_above_switch_threshold,
    input wire logic i_thermistor_sense,
    input wire logic i_switch_sense,
    input wire logic i_app_on,
    input wire logic i_supply_ok,
    input wire logic i_input_limit_hit,
    input wire logic i_current_limit_hit,
    input wire logic i_voltage_limit_hit,
    output logic o_converter_enable,
    output logic o_safe_current_select,
    output logic o_pre_current_select,
    output logic o_constant_voltage,
    output logic o_thermistor_power,
    output logic o_switch_detect_pull,
    output logic o_isolation_switch_drive,
    output logic [1:0] o_loop_select,
    output logic [3:0] o_applied_charge_current,
    output logic [5:0] o_applied_charge_voltage,
    output logic [2:0] o_applied_input_limit
);
    import charge_ctrl_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // one ramp step of a value toward its target, width up to 6 bits
    function automatic logic [5:0] step_toward(input logic [5:0] cur, input logic [5:0] tgt);
        if (cur < tgt) begin
            step_toward = cur + 6'h01;
        end else if (cur > tgt) begin
            step_toward = cur - 6'h01;
        end else begin
            step_toward = cur;
        end
    endfunction : step_toward

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 17;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic [NSYNC-1:0] raw_in;
    assign raw_in = {i_vin_detect, i_headroom_ok, i_above_safe, i_above_pre, i_near_charge_voltage,
                     i_above_recharge, i_below_end_current, i_above_switch_threshold,
                     i_thermistor_sense, i_switch_sense, i_app_on, i_supply_ok,
                     i_input_limit_hit, i_current_limit_hit, i_voltage_limit_hit, 2'b00};
    // two flops on every analog flag; only sync_b is read by logic
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end
    logic vin_det, headroom, above_safe, above_pre, near_cv, above_rechg, below_eoc;
    logic above_sw, therm_sense, sw_sense, app_on, supply_ok, lim_in, lim_i, lim_v;
    assign {vin_det, headroom, above_safe, above_pre, near_cv, above_rechg, below_eoc,
            above_sw, therm_sense, sw_sense, app_on, supply_ok, lim_in, lim_i, lim_v} = sync_b[NSYNC-1:2];

    // ------------------------------------------------------------
    // host registers
    // ------------------------------------------------------------
    logic [7:0] primary_control;
    logic [7:0] battery_current_config;
    logic [7:0] charge_voltage;
    logic [7:0] misc_settings;
    logic stack_reset;
    logic bus_ok;
    logic charge_run_enable;
    // bus works whenever internal supply is above undervoltage, input or not
    assign bus_ok = supply_ok;
    assign stack_reset = bus_ok && i_wr && (i_addr == OFF_PRIMARY_CONTROL) && i_wdata[POS_REG_STACK_RESET];
    assign charge_run_enable = primary_control[POS_CHARGE_RUN_ENABLE];

    // writes accepted in any charge state, no sequence stop
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            primary_control <= RST_PRIMARY_CONTROL;
            battery_current_config <= RST_BATTERY_CURRENT_CONFIG;
            charge_voltage <= RST_CHARGE_VOLTAGE;
            misc_settings <= RST_MISC_SETTINGS;
        end else if (stack_reset) begin
            // self-clearing reset bit restores every default
            primary_control <= RST_PRIMARY_CONTROL;
            battery_current_config <= RST_BATTERY_CURRENT_CONFIG;
            charge_voltage <= RST_CHARGE_VOLTAGE;
            misc_settings <= RST_MISC_SETTINGS;
        end else if (bus_ok && i_wr) begin
            case (i_addr)
                OFF_PRIMARY_CONTROL: primary_control <= {1'b0, i_wdata[6:0]};
                OFF_BATTERY_CURRENT_CONFIG: battery_current_config <= {1'b0, i_wdata[6:0]};
                OFF_CHARGE_VOLTAGE: charge_voltage <= {2'b00, i_wdata[5:0]};
                OFF_MISC_SETTINGS: misc_settings <= {1'b0, i_wdata[6:0]};
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // charge state machine
    // ------------------------------------------------------------
    charge_state_t state;
    charge_state_t next_state;
    logic unplug;
    assign unplug = !vin_det || !headroom;

    // config lasts long enough for the pulled pin to reach the synchronised sense
    logic [1:0] cfg_cnt;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_cnt <= 2'h0;
        end else begin
            cfg_cnt <= (state == ST_CONFIG) ? cfg_cnt + 2'h1 : 2'h0;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (vin_det && headroom) begin
                    next_state = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (cfg_cnt == CFG_WAIT_LAST) begin
                    next_state = ST_SAFE; // report presence then auto-start
                end
            end
            ST_SAFE: begin
                if (above_safe) begin
                    next_state = ST_PRE;
                end
            end
            ST_PRE: begin
                if (above_pre) begin
                    next_state = ST_FULL;
                end
            end
            ST_FULL: begin
                if (above_rechg && below_eoc) begin
                    next_state = ST_EOC;
                end
            end
            ST_EOC: begin
                if (!above_rechg) begin
                    next_state = ST_FULL;
                end
            end
            ST_FAULT: begin
                if (charge_run_enable) begin
                    next_state = ST_SAFE;
                end
            end
            default: next_state = ST_OFF;
        endcase
        // unplug beats everything, then the host hold
        if (unplug) begin
            next_state = ST_OFF;
        end else if (!charge_run_enable && state != ST_OFF && state != ST_CONFIG) begin
            next_state = ST_FAULT;
        end
        if (!above_safe && (next_state == ST_PRE)) begin
            next_state = ST_SAFE; // empty battery stays safe
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // switch and thermistor detection
    // ------------------------------------------------------------
    logic switch_present;
    logic thermistor_present;
    logic detect_done;
    // sampled once in config, held until unplug or stack reset
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            switch_present <= 1'b0;
            thermistor_present <= 1'b0;
            detect_done <= 1'b0;
        end else if (stack_reset || state == ST_OFF) begin
            detect_done <= 1'b0;
            switch_present <= 1'b0;
            thermistor_present <= 1'b0;
        end else if (state == ST_CONFIG && cfg_cnt == CFG_WAIT_LAST) begin
            switch_present <= sw_sense; // pin held low means no switch fitted
            thermistor_present <= therm_sense;
            detect_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // setting ramps
    // ------------------------------------------------------------
    logic [10:0] step_cnt;
    logic step_tick;
    // one step per 10 us so the regulation loops see small disturbances
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            step_cnt <= '0;
            step_tick <= 1'b0;
        end else begin
            step_tick <= (step_cnt == STEP_LAST);
            step_cnt <= (step_cnt == STEP_LAST) ? 11'h000 : step_cnt + 11'h001;
        end
    end

    logic [5:0] ramp_i;
    logic [5:0] ramp_v;
    logic [5:0] ramp_lim;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ramp_i <= '0;
            ramp_v <= '0;
            ramp_lim <= '0;
        end else if (step_tick) begin
            ramp_i <= step_toward(ramp_i, {2'b00, battery_current_config[POS_CHARGE_CURRENT +: 4]});
            ramp_v <= step_toward(ramp_v, charge_voltage[5:0]);
            ramp_lim <= step_toward(ramp_lim, {3'b000, misc_settings[POS_INPUT_LIMIT +: 3]});
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic next_switch_open;
    // open only for deep-discharged insertion with application off
    assign next_switch_open = switch_present && !above_sw && !app_on &&
                              (state == ST_SAFE || state == ST_PRE);

    logic [1:0] next_loop;
    // highest-priority loop at its limit takes the duty control: input, then current, then voltage
    always_comb begin
        if (lim_in) begin
            next_loop = LOOP_INPUT;
        end else if (lim_i) begin
            next_loop = LOOP_CURRENT;
        end else if (lim_v) begin
            next_loop = LOOP_VOLTAGE;
        end else begin
            next_loop = LOOP_NONE;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_converter_enable <= 1'b0;
            o_safe_current_select <= 1'b0;
            o_pre_current_select <= 1'b0;
            o_constant_voltage <= 1'b0;
            o_thermistor_power <= 1'b1;
            o_switch_detect_pull <= 1'b0;
            o_isolation_switch_drive <= 1'b0;
            o_loop_select <= 2'b00;
            o_applied_charge_current <= '0;
            o_applied_charge_voltage <= '0;
            o_applied_input_limit <= '0;
        end else begin
            o_safe_current_select <= (next_state == ST_SAFE);
            o_converter_enable <= (next_state == ST_PRE) || (next_state == ST_FULL);
            o_pre_current_select <= (next_state == ST_PRE);
            o_constant_voltage <= (next_state == ST_FULL) && near_cv;
            // thermistor powered down only in fault with its enable cleared
            o_thermistor_power <= !((state == ST_FAULT) && !primary_control[POS_THERMISTOR_BLOCK_ENABLE]);
            o_switch_detect_pull <= (next_state == ST_CONFIG);
            o_isolation_switch_drive <= next_switch_open;
            o_loop_select <= (next_state == ST_FULL || next_state == ST_PRE) ? next_loop : 2'b00;
            o_applied_charge_current <= ramp_i[3:0];
            o_applied_charge_voltage <= ramp_v;
            o_applied_input_limit <= ramp_lim[2:0];
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_rd && bus_ok) begin
            case (i_addr)
                OFF_PRIMARY_CONTROL: o_rdata <= primary_control;
                OFF_BATTERY_CURRENT_CONFIG: o_rdata <= battery_current_config;
                OFF_CHARGE_VOLTAGE: o_rdata <= charge_voltage;
                OFF_MISC_SETTINGS: o_rdata <= misc_settings;
                OFF_STATUS: o_rdata <= {2'b00, switch_present, thermistor_present, detect_done, state};
                OFF_APPLIED: o_rdata <= {ramp_lim[1:0], ramp_v};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_off_startup: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ST_OFF && $past(state) == ST_OFF) |=> (state == ST_OFF) || $past(vin_det && headroom))
        else $error("left off without valid input");
    a_hold_to_fault: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!charge_run_enable && !unplug && state inside {ST_SAFE, ST_PRE, ST_FULL, ST_EOC}) |=> state == ST_FAULT)
        else $error("host hold did not reach fault");
    a_safe_to_pre: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ST_SAFE && above_safe && charge_run_enable && !unplug) |=> state == ST_PRE)
        else $error("safe phase did not advance");
    a_eoc_resume: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ST_EOC && !above_rechg && charge_run_enable && !unplug) |=> state == ST_FULL)
        else $error("no resume from end of charge");
    a_full_to_eoc: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ST_FULL && above_rechg && below_eoc && charge_run_enable && !unplug) |=> state == ST_EOC)
        else $error("end of charge missed");
    a_switch_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        above_sw |=> !o_isolation_switch_drive)
        else $error("switch open above threshold");
    a_stack_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        stack_reset |=> primary_control == RST_PRIMARY_CONTROL && charge_voltage == RST_CHARGE_VOLTAGE)
        else $error("stack reset left registers");
    a_ramp_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !step_tick |=> $stable(ramp_i) && $stable(ramp_v))
        else $error("ramp moved between steps");
    a_detect_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (detect_done && state != ST_OFF && !stack_reset) |=> $stable(switch_present))
        else $error("detection result changed mid cycle");
    a_config_pull: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ST_CONFIG) |-> o_switch_detect_pull)
        else $error("no detection pull in config");
    c_full_charge: cover property (@(posedge i_ref_clk) disable iff (i_rst) state == ST_FULL);
    c_eoc: cover property (@(posedge i_ref_clk) disable iff (i_rst) state == ST_EOC);
    c_fault: cover property (@(posedge i_ref_clk) disable iff (i_rst) state == ST_FAULT);
    c_switch_open: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_isolation_switch_drive);
endmodule : charge_ctrl

`default_nettype wire

// ### verilog/charge_ctrl_pkg.sv
// package for the single-cell charge sequencing controller
// holds register offsets, field positions, reset values, timing counts and state encoding
package charge_ctrl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [3:0] OFF_PRIMARY_CONTROL = 4'h0;
    localparam logic [3:0] OFF_BATTERY_CURRENT_CONFIG = 4'h1;
    localparam logic [3:0] OFF_CHARGE_VOLTAGE = 4'h2;
    localparam logic [3:0] OFF_MISC_SETTINGS = 4'h3;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_APPLIED = 4'h5;
    // primary_control fields
    localparam int POS_CHARGE_RUN_ENABLE = 0;
    localparam int POS_THERMISTOR_BLOCK_ENABLE = 1;
    localparam int POS_REG_STACK_RESET = 7;
    // battery_current_config fields
    localparam int POS_CHARGE_CURRENT = 0;
    localparam int POS_END_CURRENT = 4;
    // misc fields
    localparam int POS_SWITCH_THRESHOLD_SELECT = 0;
    localparam int POS_INPUT_LIMIT = 4;
    // reset values
    localparam logic [7:0] RST_PRIMARY_CONTROL = 8'h03;
    localparam logic [7:0] RST_BATTERY_CURRENT_CONFIG = 8'h20;
    localparam logic [7:0] RST_CHARGE_VOLTAGE = 8'h00;
    localparam logic [7:0] RST_MISC_SETTINGS = 8'h00;
    // timing: 10 us per scaling step at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_TIME_US = 10;
    localparam int STEP_CYCLES = (STEP_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam logic [10:0] STEP_LAST = 11'(STEP_CYCLES - 1);
    // last config cycle: the detection pull must have crossed the two sense flops first
    localparam logic [1:0] CFG_WAIT_LAST = 2'h3;
    // charge states, gray along off-config-safe-pre-full-eoc
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_CONFIG = 3'b001,
        ST_SAFE = 3'b011,
        ST_PRE = 3'b010,
        ST_FULL = 3'b110,
        ST_EOC = 3'b111,
        ST_FAULT = 3'b101
    } charge_state_t;
    // selected regulation loop
    typedef enum logic [1:0] {
        LOOP_NONE = 2'b00,
        LOOP_INPUT = 2'b01,
        LOOP_CURRENT = 2'b10,
        LOOP_VOLTAGE = 2'b11
    } loop_sel_t;
endpackage : charge_ctrl_pkg

// ### test/batt_model.sv
// behavioural model of the analog front end beside the charge controller
// turns an abstract battery level into the comparator flags the controller sees
// assumes thresholds ordered safe < pre < switch < recharge < near charge voltage
`timescale 1ns/1ps
`default_nettype none
module batt_model #(
    parameter int LV_SAFE = 20,
    parameter int LV_PRE = 30,
    parameter int LV_SWITCH = 35,
    parameter int LV_RECHARGE = 40,
    parameter int LV_NEAR = 45
) (
    input wire logic [7:0] i_level,
    input wire logic i_detect_pull,
    input wire logic i_switch_fitted,
    output logic o_above_safe,
    output logic o_above_pre,
    output logic o_above_switch_threshold,
    output logic o_above_recharge,
    output logic o_near_charge_voltage,
    output logic o_switch_sense
);
    // a fitted switch lets the weak pull lift its pin; without one the pin is grounded
    assign o_switch_sense = i_detect_pull && i_switch_fitted;
    // plain level compares; deglitching is taken as already done upstream
    assign o_above_safe = int'(i_level) >= LV_SAFE;
    assign o_above_pre = int'(i_level) >= LV_PRE;
    assign o_above_switch_threshold = int'(i_level) >= LV_SWITCH;
    assign o_above_recharge = int'(i_level) >= LV_RECHARGE;
    assign o_near_charge_voltage = int'(i_level) >= LV_NEAR;
endmodule : batt_model
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the charge sequencing controller
// assumes 2-cycle flag synchroniser and one-cycle registered read data
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import charge_ctrl_pkg::*;
    logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, level = 8'h00, rv;
    logic vin = 0, head = 0, eoc_i = 0, therm = 0, sw = 0, app = 0, sup = 1, lim_i = 0, lim_c = 0, lim_v = 0;
    logic a_safe, a_pre, a_sw, a_rech, a_near, sw_pin;
    logic conv, safe_sel, pre_sel, cv, tpow, pull, drv;
    logic [1:0] loop_sel;
    logic [3:0] app_i;
    logic [5:0] app_v;
    logic [2:0] app_l;
    int n_mismatch = 0, num_checks = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    batt_model i_model (.i_level(level), .i_detect_pull(pull), .i_switch_fitted(sw), .o_above_safe(a_safe),
        .o_above_pre(a_pre), .o_above_switch_threshold(a_sw), .o_above_recharge(a_rech),
        .o_near_charge_voltage(a_near), .o_switch_sense(sw_pin));
    charge_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(rv), .i_vin_detect(vin), .i_headroom_ok(head), .i_above_safe(a_safe),
        .i_above_pre(a_pre), .i_near_charge_voltage(a_near), .i_above_recharge(a_rech),
        .i_below_end_current(eoc_i), .i_above_switch_threshold(a_sw), .i_thermistor_sense(therm),
        .i_switch_sense(sw_pin), .i_app_on(app), .i_supply_ok(sup), .i_input_limit_hit(lim_i),
        .i_current_limit_hit(lim_c), .i_voltage_limit_hit(lim_v), .o_converter_enable(conv),
        .o_safe_current_select(safe_sel), .o_pre_current_select(pre_sel), .o_constant_voltage(cv),
        .o_thermistor_power(tpow), .o_switch_detect_pull(pull), .o_isolation_switch_drive(drv),
        .o_loop_select(loop_sel), .o_applied_charge_current(app_i), .o_applied_charge_voltage(app_v),
        .o_applied_input_limit(app_l));
    // ----------------------------------------
    // shared bus and compare tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = rv;
    endtask : rd
    task automatic st(input charge_state_t s);
        logic [7:0] d;
        rd(OFF_STATUS, d);
        check({5'h0, d[2:0]}, {5'h0, s});
    endtask : st
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [7:0] d;
        rd(OFF_PRIMARY_CONTROL, d); check(d, RST_PRIMARY_CONTROL);
        rd(OFF_BATTERY_CURRENT_CONFIG, d); check(d, RST_BATTERY_CURRENT_CONFIG);
        rd(OFF_CHARGE_VOLTAGE, d); check(d, RST_CHARGE_VOLTAGE);
        rd(OFF_MISC_SETTINGS, d); check(d, RST_MISC_SETTINGS);
        rd(4'hf, d); check(d, 8'h00);
        wr(OFF_BATTERY_CURRENT_CONFIG, 8'h55);
        rd(OFF_BATTERY_CURRENT_CONFIG, d); check(d, 8'h55);
        wr(OFF_PRIMARY_CONTROL, 8'h83); // stack reset, with one idle cycle before the read strobe
        rd(OFF_BATTERY_CURRENT_CONFIG, d); check(d, RST_BATTERY_CURRENT_CONFIG);
        $display("test regs done");
    endtask : t_regs
    task automatic t_start;
        logic [7:0] d;
        sw <= 1'b1; therm <= 1'b1; vin <= 1'b1;
        tick(10); st(ST_OFF);
        head <= 1'b1;
        tick(8); st(ST_SAFE);
        check({7'h0, safe_sel}, 8'h01);
        rd(OFF_STATUS, d); check({5'h0, d[5:3]}, 8'h07);
        check({7'h0, drv}, 8'h01);
        $display("test start done");
    endtask : t_start
    task automatic t_phases;
        level <= 8'd25; tick(6); st(ST_PRE);
        check({6'h0, pre_sel, conv}, 8'h03);
        level <= 8'd36; tick(6); st(ST_FULL);
        check({6'h0, conv, drv}, 8'h02);
        lim_c <= 1'b1; tick(6); check({6'h0, loop_sel}, 8'h02);
        lim_c <= 1'b0; lim_i <= 1'b1; tick(6); check({6'h0, loop_sel}, 8'h01);
        lim_i <= 1'b0; lim_v <= 1'b1; level <= 8'd46; tick(6); check({7'h0, cv}, 8'h01);
        check({6'h0, loop_sel}, 8'h03);
        lim_v <= 1'b0; eoc_i <= 1'b1; tick(6); st(ST_EOC);
        check({7'h0, conv}, 8'h00);
        level <= 8'd38; tick(6); st(ST_FULL);
        check({7'h0, cv}, 8'h00);
        eoc_i <= 1'b0;
        $display("test phases done");
    endtask : t_phases
    // one ramp step per 1000 cycles, so three steps cannot be complete after 1100
    task automatic t_ramp;
        logic [7:0] d;
        wr(OFF_BATTERY_CURRENT_CONFIG, 8'h23);
        wr(OFF_CHARGE_VOLTAGE, 8'h02);
        wr(OFF_MISC_SETTINGS, 8'h20);
        tick(1100); check({7'h0, app_i < 4'h3}, 8'h01);
        tick(2100); check({4'h0, app_i}, 8'h03);
        check({2'h0, app_v}, 8'h02);
        check({5'h0, app_l}, 8'h02);
        rd(OFF_APPLIED, d); check(d, 8'h82);
        st(ST_FULL);
        $display("test ramp done");
    endtask : t_ramp
    task automatic t_fault;
        wr(OFF_PRIMARY_CONTROL, 8'h02); tick(3); st(ST_FAULT);
        check({6'h0, conv, tpow}, 8'h01);
        wr(OFF_PRIMARY_CONTROL, 8'h00); tick(3); check({7'h0, tpow}, 8'h00);
        $display("test fault done");
    endtask : t_fault
    task automatic t_unplug;
        logic [7:0] d;
        vin <= 1'b0; tick(8);
        rd(OFF_STATUS, d); check({7'h0, d[3]}, 8'h00);
        wr(OFF_CHARGE_VOLTAGE, 8'h15);
        rd(OFF_CHARGE_VOLTAGE, d); check(d, 8'h15);
        sup <= 1'b0; tick(4); wr(OFF_CHARGE_VOLTAGE, 8'h2a);
        sup <= 1'b1; tick(4); rd(OFF_CHARGE_VOLTAGE, d); check(d, 8'h15);
        // replug with no switch fitted and an empty cell: detection redone, switch kept closed
        wr(OFF_PRIMARY_CONTROL, 8'h03);
        sw <= 1'b0; level <= 8'd0; vin <= 1'b1; tick(12); st(ST_SAFE);
        rd(OFF_STATUS, d); check({5'h0, d[5:3]}, 8'h03);
        check({7'h0, drv}, 8'h00);
        $display("test unplug done");
    endtask : t_unplug
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // all scenarios need well under 5000 cycles; 20000 is a hang
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        tick(20);
        i_rst <= 1'b0;
        tick(3);
        t_regs(); t_start(); t_phases(); t_ramp(); t_fault(); t_unplug();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
